// ==== bench/fcif_flash_model.sv ====
/*
 * fcif_flash_model: behavioural flash macro behind the controller.
 * assumes one write pulse per half-word; busy after each write.
 */
`timescale 1ns/1ps
`default_nettype none
module fcif_flash_model
	import fcif_pkg::*;
#(
	parameter int BUSY_CYC = 20
)(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [22:0] haddr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        rd_in,
	input  wire logic        wr_in,
	output logic             ready_out,
	output logic [31:0]      rdata_out
);
	logic [15:0] mem_reg [0:127];
	logic [7:0]  busy_reg;
	logic [31:0] word_w;
	assign word_w    = {mem_reg[{haddr_in[6:1], 1'b0}], mem_reg[{haddr_in[6:1], 1'b1}]};
	assign ready_out = (busy_reg == 8'h00);
	// read data toggles outside reads so a stale word is never mistaken for fresh
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_reg  <= 8'h00;
			rdata_out <= 32'h0;
			for (int i = 0; i < 128; i++) begin
				mem_reg[i] <= 16'h1000 + 16'(i);
			end
		end else begin
			if (wr_in) begin
				mem_reg[haddr_in[6:0]] <= wdata_in;
				busy_reg               <= 8'(BUSY_CYC);
			end else if (busy_reg != 8'h00) begin
				busy_reg <= busy_reg - 8'h01;
			end
			rdata_out <= rd_in ? word_w : ~rdata_out;
		end
	end
endmodule
`default_nettype wire

// ==== bench/test_flash_cpu_interface.sv ====
/*
 * test_flash_cpu_interface: self-checking bench of the flash cpu interface.
 * assumes the flash model as far side and an avalon master of its own.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_flash_cpu_interface
	import fcif_pkg::*;
;
	logic        clk, resetn, read, write, cpu, fready, fwr, frd, lowp, irq, waitreq;
	logic [23:0] addr;
	logic [31:0] wdata, rdata, frdata, rdat;
	logic [3:0]  ben, sector, sec_s;
	logic [22:0] haddr, ha_s;
	logic [15:0] fwd, wd_s;
	logic        wr_s;
	int          cyc, cr, n_errors, num_checks;
	logic [23:0] bases [5] = '{SEC0_BASE, SEC1_BASE, SEC2_BASE, SEC3_BASE, SEC4_BASE};

	fcif_flash_ctrl i_dut (.REF_CLK_IN(clk), .RESETN_IN(resetn), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(read),
		.AVS_WRITE_IN(write), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(ben), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(waitreq), .CPU_MODE_IN(cpu), .FLASH_READY_IN(fready), .FLASH_RDATA_IN(frdata),
		.FLASH_HADDR_OUT(haddr), .FLASH_WDATA_OUT(fwd), .FLASH_RD_OUT(frd), .FLASH_WR_OUT(fwr),
		.FLASH_SECTOR_OUT(sector), .FLASH_LOW_POWER_OUT(lowp), .IRQ_OUT(irq));
	fcif_flash_model i_flash (.clk_in(clk), .rst_n_in(resetn), .haddr_in(haddr), .wdata_in(fwd),
		.rd_in(frd), .wr_in(fwr), .ready_out(fready), .rdata_out(frdata));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// one plain read or write per call: the status register must not see read-modify-write
	task automatic bus(input logic wr, input logic [23:0] a, input logic [31:0] d, input logic [3:0] be);
		cyc = 0;
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		ben   <= be;
		write <= wr;
		read  <= !wr;
		do begin
			@(posedge clk);
			cyc++;
		end while (waitreq !== 1'b0 && cyc < 100);
		if (cyc >= 100) n_errors++;
		rdat  = rdata;
		wr_s  = fwr;
		ha_s  = haddr;
		wd_s  = fwd;
		sec_s = sector;
		write <= 1'b0;
		read  <= 1'b0;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		bus(1'b0, OFS_STATUS_CTL, 32'h0, 4'hf);
		cr = cyc;
		`CHK(rdat[7:0], 8'h10)
		`CHK(lowp, 1'b0)
		bus(1'b0, OFS_WAIT_CTL, 32'h0, 4'hf);
		`CHK(rdat[7:0], 8'h00)
	endtask

	task automatic t_regs();
		bus(1'b1, OFS_WAIT_CTL, 32'h07, 4'hf);
		bus(1'b0, OFS_WAIT_CTL, 32'h0, 4'hf);
		`CHK(rdat[7:0], 8'h03)
		bus(1'b1, OFS_STATUS_CTL, 32'ha1, 4'hf);
		bus(1'b0, OFS_STATUS_CTL, 32'h0, 4'hf);
		`CHK(rdat[7:0], 8'hb1)
		`CHK(lowp, 1'b1)
		@(posedge clk);
		cpu <= 1'b0;
		bus(1'b0, OFS_STATUS_CTL, 32'h0, 4'hf);
		`CHK(rdat[7:0], 8'h00)
		bus(1'b1, OFS_STATUS_CTL, 32'h00, 4'hf);
		bus(1'b1, OFS_WAIT_CTL, 32'h00, 4'hf);
		@(posedge clk);
		cpu <= 1'b1;
		bus(1'b0, OFS_STATUS_CTL, 32'h0, 4'hf);
		`CHK(rdat[7:0], 8'hb1)
		bus(1'b0, OFS_WAIT_CTL, 32'h0, 4'hf);
		`CHK(rdat[7:0], 8'h03)
		bus(1'b0, 24'h0007e0, 32'h0, 4'hf);
		`CHK(rdat, 32'h0)
		bus(1'b1, OFS_STATUS_CTL, 32'h00, 4'hf);
	endtask

	// k = 1 programs wait 01, the setting that allows a clock above 25 MHz
	task automatic t_read();
		int e;
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, OFS_WAIT_CTL, (k == 4) ? 32'h04 : 32'(k), 4'hf);
			bus(1'b0, 24'h0e0040, 32'h0, 4'hf);
			e = (k == 4) ? int'(FAST_CYC) : int'(NORM_CYC) * (k + 1);
			`CHK(rdat, 32'h10201021)
			`CHK(cyc - cr, e)
		end
		bus(1'b1, OFS_WAIT_CTL, 32'h00, 4'hf);
	endtask

	task automatic t_write();
		logic [23:0] a;
		logic [31:0] d;
		bus(1'b1, OFS_INT_CLEAR, 32'h3, 4'hf);
		bus(1'b1, 24'h0e0000, 32'h0000abcd, 4'h3);
		`CHK(wr_s, 1'b0)
		bus(1'b0, OFS_INT_STATUS, 32'h0, 4'hf);
		`CHK(rdat[IS_BLOCKED], 1'b1)
		bus(1'b1, OFS_STATUS_CTL, 32'h20, 4'hf);
		// a full-word write is no half-word program, so it must be refused
		bus(1'b1, OFS_INT_CLEAR, 32'h2, 4'hf);
		bus(1'b1, 24'h0e0000, 32'h0000abcd, 4'hf);
		`CHK(wr_s, 1'b0)
		bus(1'b0, OFS_INT_STATUS, 32'h0, 4'hf);
		`CHK(rdat[IS_BLOCKED], 1'b1)
		for (int i = 0; i < 10; i++) begin
			a = bases[i % 5];
			d = {16'hc000 + 16'(i), 16'h3000 + 16'(i)};
			bus(1'b1, a, d, (i < 5) ? 4'hc : 4'h3);
			`CHK(wr_s, 1'b1)
			`CHK(ha_s, {a[23:2], i >= 5})
			`CHK(wd_s, (i < 5) ? d[31:16] : d[15:0])
			`CHK(sec_s, 4'(i))
			if (i % 5 != 0) begin
				bus(1'b1, a - 24'h4, d, (i < 5) ? 4'hc : 4'h3);
				`CHK(sec_s, 4'(i - 1))
			end
		end
		bus(1'b0, OFS_LAST_SECTOR, 32'h0, 4'hf);
		`CHK(rdat[3:0], 4'h8)
	endtask

	task automatic t_irq();
		cyc = 0;
		while (fready !== 1'b1 && cyc < 200) begin
			@(posedge clk);
			cyc++;
		end
		bus(1'b1, OFS_STATUS_CTL, 32'ha0, 4'hf);
		bus(1'b1, OFS_INT_CLEAR, 32'h3, 4'hf);
		settle();
		`CHK(irq, 1'b0)
		bus(1'b1, 24'h0f8000, 32'h12345678, 4'hc);
		cyc = 0;
		while (irq !== 1'b1 && cyc < 200) begin
			@(posedge clk);
			cyc++;
		end
		`CHK(irq, 1'b1)
		bus(1'b0, OFS_STATUS_CTL, 32'h0, 4'hf);
		`CHK(rdat[7:0], 8'hf0)
		bus(1'b1, OFS_STATUS_CTL, 32'h60, 4'hf);
		settle();
		`CHK(irq, 1'b0)
		bus(1'b1, OFS_STATUS_CTL, 32'he0, 4'hf);
		settle();
		`CHK(irq, 1'b1)
		bus(1'b1, OFS_STATUS_CTL, 32'ha0, 4'hf);
		settle();
		`CHK(irq, 1'b0)
		bus(1'b1, OFS_INT_ENABLE, 32'h1, 4'hf);
		settle();
		`CHK(irq, 1'b1)
		bus(1'b1, OFS_INT_CLEAR, 32'h1, 4'hf);
		settle();
		`CHK(irq, 1'b0)
		bus(1'b0, OFS_INT_STATUS, 32'h0, 4'hf);
		`CHK(rdat[1:0], 2'b00)
	endtask

	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// whole run is a few hundred cycles; this bound only catches a hang
	initial begin
		#100000;
		n_errors++;
		results();
	end

	initial begin
		n_errors   = 0;
		num_checks = 0;
		resetn     = 1'b0;
		read       = 1'b0;
		write      = 1'b0;
		cpu        = 1'b1;
		addr       = 24'h0;
		wdata      = 32'h0;
		ben        = 4'hf;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_regs();
		t_read();
		t_write();
		t_irq();
		results();
	end
endmodule
`default_nettype wire

// ==== rtl/fcif_core_if.sv ====
/*
 * fcif_core_if: links the controller to its sector map and wait timer.
 * assumes one clock domain; no timing of its own.
 */
`timescale 1ns/1ps
`default_nettype none
interface fcif_core_if;
	logic [23:0] addr;
	logic        hit;
	logic [2:0]  sector;
	logic        load;
	logic [5:0]  load_val;
	logic        expired;
	modport ctrl (output addr, output load, output load_val, input hit, input sector, input expired);
	modport map (input addr, output hit, output sector);
	modport timer (input load, input load_val, output expired);
endinterface
`default_nettype wire

// ==== rtl/fcif_flash_ctrl.sv ====
/*
 * fcif_flash_ctrl: cpu-side interface of the on-chip flash array.
 * an avalon-mm slave with waitrequest reaches the array and the registers;
 * the flash macro itself, with its command decoder, sits outside.
 */
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module fcif_flash_ctrl
	import fcif_pkg::*;
(
	input  wire logic        REF_CLK_IN,
	input  wire logic        RESETN_IN,
	input  wire logic [23:0] AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	input  wire logic [3:0]  AVS_BYTEENABLE_IN,
	output logic [31:0]      AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	input  wire logic        CPU_MODE_IN,
	input  wire logic        FLASH_READY_IN,
	input  wire logic [31:0] FLASH_RDATA_IN,
	output logic [22:0]      FLASH_HADDR_OUT,
	output logic [15:0]      FLASH_WDATA_OUT,
	output logic             FLASH_RD_OUT,
	output logic             FLASH_WR_OUT,
	output logic [3:0]       FLASH_SECTOR_OUT,
	output logic             FLASH_LOW_POWER_OUT,
	output logic             IRQ_OUT
);
	fcif_core_if cif ();

	fcif_sector_map u_map (
		.m (cif)
	);

	fcif_wait_timer u_timer (
		.clk   (REF_CLK_IN),
		.rst_n (RESETN_IN),
		.t     (cif)
	);

	fcif_state_type state_reg;
	fcif_state_type state_next;
	logic [23:0] addr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  be_reg;
	logic        is_write_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [7:0]  status_ctl_reg;
	logic [7:0]  status_ctl_next;
	logic [2:0]  wait_ctl_reg;
	logic [2:0]  wait_ctl_next;
	logic [1:0]  int_status_reg;
	logic [1:0]  int_status_next;
	logic [1:0]  int_enable_reg;
	logic [3:0]  last_sector_reg;
	logic        ready_prev_reg;

	wire req          = AVS_READ_IN || AVS_WRITE_IN;
	wire accept       = (state_reg == ST_IDLE) && req;
	wire done         = (state_reg == ST_DONE);
	wire sel_flash    = cif.hit;
	// registers vanish outside cpu mode
	wire reg_ok       = CPU_MODE_IN;
	wire sel_sc       = reg_ok && (addr_reg == OFS_STATUS_CTL);
	wire sel_wt       = reg_ok && (addr_reg == OFS_WAIT_CTL);
	wire sel_is       = reg_ok && (addr_reg == OFS_INT_STATUS);
	wire sel_ic       = reg_ok && (addr_reg == OFS_INT_CLEAR);
	wire sel_ie       = reg_ok && (addr_reg == OFS_INT_ENABLE);
	wire sel_ls       = reg_ok && (addr_reg == OFS_LAST_SECTOR);
	wire reg_wr       = done && is_write_reg;
	// exactly one half-word lane per program write
	wire half_hi      = (be_reg == 4'hc);
	wire half_lo      = (be_reg == 4'h3);
	wire half_ok      = half_hi || half_lo;
	wire wr_enable    = status_ctl_reg[SC_WR_EN];
	wire flash_wr_try = reg_wr && sel_flash;
	wire flash_wr_go  = flash_wr_try && half_ok && wr_enable;
	wire flash_wr_bad = flash_wr_try && !flash_wr_go;
	wire ready_rise   = FLASH_READY_IN && !ready_prev_reg;
	wire high_speed   = wait_ctl_reg[WT_HIGH_SPEED];
	wire [5:0] wait_mul = {4'h0, wait_ctl_reg[1:0]} + 6'h01;
	// high speed bit beats the wait field
	wire [5:0] rd_cyc = high_speed ? FAST_CYC : 6'(NORM_CYC * wait_mul);
	// sector of the lane in use: low half sits five sectors up
	wire [3:0] sector_eff = half_lo ? 4'({1'b0, cif.sector} + {1'b0, LOW_HALF_OFS}) : {1'b0, cif.sector};

	assign cif.addr     = accept ? AVS_ADDRESS_IN : addr_reg;
	assign cif.load     = accept;
	assign cif.load_val = (AVS_READ_IN && cif.hit) ? rd_cyc : REG_CYC;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req)
					state_next = ST_WAIT;
			end
			ST_WAIT: begin
				if (cif.expired)
					state_next = ST_DONE;
			end
			ST_DONE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// full word from both halves; unused bits read as zero
	always_comb begin
		rdata_next = rdata_reg;
		if ((state_reg == ST_WAIT) && cif.expired && !is_write_reg) begin
			rdata_next = 32'h0000_0000;
			if (sel_flash)
				rdata_next = FLASH_RDATA_IN;
			else if (sel_sc)
				rdata_next = {24'h0, status_ctl_reg[7:5], FLASH_READY_IN, 3'h0, status_ctl_reg[0]};
			else if (sel_wt)
				rdata_next = {30'h0, wait_ctl_reg[1:0]};
			else if (sel_is)
				rdata_next = {30'h0, int_status_reg};
			else if (sel_ie)
				rdata_next = {30'h0, int_enable_reg};
			else if (sel_ls)
				rdata_next = {28'h0, last_sector_reg};
		end
	end

	// software clears the ready flag by writing it zero; a new edge wins
	always_comb begin
		status_ctl_next = status_ctl_reg;
		if (reg_wr && sel_sc) begin
			status_ctl_next[SC_IRQ_EN]  = wdata_reg[SC_IRQ_EN];
			status_ctl_next[SC_WR_EN]   = wdata_reg[SC_WR_EN];
			status_ctl_next[SC_LOW_PWR] = wdata_reg[SC_LOW_PWR];
			status_ctl_next[SC_RDY_FLAG] = status_ctl_reg[SC_RDY_FLAG] && wdata_reg[SC_RDY_FLAG];
		end
		if (ready_rise)
			status_ctl_next[SC_RDY_FLAG] = 1'b1;
		status_ctl_next[4:1] = 4'h0;
	end

	assign wait_ctl_next = (reg_wr && sel_wt) ? wdata_reg[2:0] : wait_ctl_reg;

	// sticky events; set wins over clear in the same cycle
	assign int_status_next = (int_status_reg & ~((reg_wr && sel_ic) ? wdata_reg[1:0] : 2'b00))
	                       | {flash_wr_bad, ready_rise};

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_reg    <= ST_IDLE;
			addr_reg     <= 24'h000000;
			wdata_reg    <= 32'h0000_0000;
			be_reg       <= 4'h0;
			is_write_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				addr_reg     <= AVS_ADDRESS_IN;
				wdata_reg    <= AVS_WRITEDATA_IN;
				be_reg       <= AVS_BYTEENABLE_IN;
				is_write_reg <= AVS_WRITE_IN;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			status_ctl_reg <= STATUS_CTL_RST;
			wait_ctl_reg   <= WAIT_CTL_RST;
			int_status_reg <= 2'b00;
			int_enable_reg <= 2'b00;
			rdata_reg      <= 32'h0000_0000;
			ready_prev_reg <= 1'b1;
		end else begin
			status_ctl_reg <= status_ctl_next;
			wait_ctl_reg   <= wait_ctl_next;
			int_status_reg <= int_status_next;
			rdata_reg      <= rdata_next;
			ready_prev_reg <= FLASH_READY_IN;
			if (reg_wr && sel_ie)
				int_enable_reg <= wdata_reg[1:0];
		end
	end

	// last programmed sector, for software to read back
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			last_sector_reg <= 4'h0;
		else if (flash_wr_go)
			last_sector_reg <= sector_eff;
	end

	assign AVS_WAITREQUEST_OUT = !done;
	assign AVS_READDATA_OUT    = rdata_reg;
	// half-word index: bit 0 picks the lane
	assign FLASH_HADDR_OUT     = {addr_reg[23:2], half_lo};
	assign FLASH_WDATA_OUT     = half_hi ? wdata_reg[31:16] : wdata_reg[15:0];
	assign FLASH_RD_OUT        = (state_reg == ST_WAIT) && !is_write_reg && sel_flash;
	// only single half-word writes with write enable set reach the macro; others are blocked
	assign FLASH_WR_OUT        = flash_wr_go;
	assign FLASH_SECTOR_OUT    = sector_eff;
	assign FLASH_LOW_POWER_OUT = status_ctl_reg[SC_LOW_PWR];
	assign IRQ_OUT = (status_ctl_reg[SC_IRQ_EN] && status_ctl_reg[SC_RDY_FLAG])
	              || |(int_status_reg & int_enable_reg);

	// the bus needs a reply even for unmapped space, so nothing here can stall forever
	logic [6:0] busy_cnt_reg;
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			busy_cnt_reg <= 7'h00;
		else if (done || state_reg == ST_IDLE)
			busy_cnt_reg <= 7'h00;
		else
			busy_cnt_reg <= busy_cnt_reg + 7'h01;
	end

	chk_busy_bounded: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		busy_cnt_reg <= 7'd33)
		else $error("access took too long");
	chk_write_blocked: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		FLASH_WR_OUT |-> status_ctl_reg[SC_WR_EN])
		else $error("flash write while write enable is zero");
	chk_one_half: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		FLASH_WR_OUT |-> (be_reg == 4'hc || be_reg == 4'h3))
		else $error("flash write not a single half-word");
	chk_low_lane_map: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		FLASH_WR_OUT && be_reg == 4'h3 |-> FLASH_SECTOR_OUT >= 4'h5 && FLASH_HADDR_OUT[0])
		else $error("low half mapped to wrong sector");
	chk_high_lane_map: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		FLASH_WR_OUT && be_reg == 4'hc |-> FLASH_SECTOR_OUT <= 4'h4 && !FLASH_HADDR_OUT[0])
		else $error("high half mapped to wrong sector");
	chk_sector_bounds: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		FLASH_WR_OUT && addr_reg >= SEC4_BASE |-> FLASH_SECTOR_OUT inside {4'h4, 4'h9})
		else $error("top sector decoded wrongly");
	chk_irq_level: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		status_ctl_reg[SC_IRQ_EN] && status_ctl_reg[SC_RDY_FLAG] |-> IRQ_OUT)
		else $error("interrupt missing for ready flag");
	chk_ready_sets_flag: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		$rose(FLASH_READY_IN) |=> status_ctl_reg[SC_RDY_FLAG])
		else $error("ready edge did not set flag");
	chk_fast_read: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		accept && AVS_READ_IN && cif.hit && high_speed |=> (!done)[*8] ##1 done)
		else $error("fast read length wrong");
	chk_no_reg_outside: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		!CPU_MODE_IN && reg_wr && addr_reg == OFS_WAIT_CTL |=> $stable(wait_ctl_reg))
		else $error("wait register written outside cpu mode");
	chk_unused_zero: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		status_ctl_reg[4:1] == 4'h0)
		else $error("unused status bits set");
	chk_hs_write_only: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		done && !is_write_reg && sel_wt |-> AVS_READDATA_OUT[31:2] == 30'h0)
		else $error("high speed bit visible on read");

	cov_flash_read: cover property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		FLASH_RD_OUT ##1 done);
	cov_flash_write: cover property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		FLASH_WR_OUT);
	cov_blocked_write: cover property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		flash_wr_bad);
	cov_irq: cover property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
		$rose(IRQ_OUT));
endmodule
`default_nettype wire

// ==== rtl/fcif_pkg.sv ====
/*
 * fcif_pkg: shared constants and types of the flash cpu interface.
 * assumes byte addresses on a 24-bit avalon-mm bus, 32-bit data.
 */
package fcif_pkg;
	localparam int          ADDR_W          = 24;
	localparam logic [23:0] OFS_STATUS_CTL  = 24'h0007c0;
	localparam logic [23:0] OFS_WAIT_CTL    = 24'h0007c4;
	localparam logic [23:0] OFS_INT_STATUS  = 24'h0007c8;
	localparam logic [23:0] OFS_INT_CLEAR   = 24'h0007cc;
	localparam logic [23:0] OFS_INT_ENABLE  = 24'h0007d0;
	localparam logic [23:0] OFS_LAST_SECTOR = 24'h0007d4;
	// sector starts of one half, lowest first
	localparam logic [23:0] SEC0_BASE       = 24'h0c0800;
	localparam logic [23:0] SEC1_BASE       = 24'h0e0000;
	localparam logic [23:0] SEC2_BASE       = 24'h0f0000;
	localparam logic [23:0] SEC3_BASE       = 24'h0f4000;
	localparam logic [23:0] SEC4_BASE       = 24'h0f8000;
	localparam logic [23:0] FLASH_LAST      = 24'h0fffff;
	localparam logic [2:0]  LOW_HALF_OFS    = 3'h5;
	// status/control field positions
	localparam int          SC_IRQ_EN       = 7;
	localparam int          SC_RDY_FLAG     = 6;
	localparam int          SC_WR_EN        = 5;
	localparam int          SC_READY        = 4;
	localparam int          SC_LOW_PWR      = 0;
	localparam int          WT_HIGH_SPEED   = 2;
	localparam logic [7:0]  STATUS_CTL_RST  = 8'h00;
	localparam logic [2:0]  WAIT_CTL_RST    = 3'h0;
	// interrupt status bits
	localparam int          IS_READY        = 0;
	localparam int          IS_BLOCKED      = 1;
	// read timing
	localparam int          CLK_PS          = 5000;
	localparam int          FAST_READ_PS    = 30300;
	localparam int          NORM_READ_PS    = 40000;
	localparam logic [5:0]  FAST_CYC        = 6'((FAST_READ_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [5:0]  NORM_CYC        = 6'((NORM_READ_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [5:0]  REG_CYC         = 6'h00;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b10
	} fcif_state_type;
endpackage

// ==== rtl/fcif_sector_map.sv ====
/*
 * fcif_sector_map: decodes a byte address into a sector of one half.
 * assumes the caller adds the offset for the low half.
 */
`timescale 1ns/1ps
`default_nettype none
module fcif_sector_map
	import fcif_pkg::*;
(
	fcif_core_if.map m
);
	wire in_range = (m.addr >= SEC0_BASE) && (m.addr <= FLASH_LAST);
	assign m.hit    = in_range;
	// 63k, 32k, 8k, 8k, 16k sectors
	assign m.sector = (m.addr >= SEC4_BASE) ? 3'h4 :
	                  (m.addr >= SEC3_BASE) ? 3'h3 :
	                  (m.addr >= SEC2_BASE) ? 3'h2 :
	                  (m.addr >= SEC1_BASE) ? 3'h1 : 3'h0;
endmodule
`default_nettype wire

// ==== rtl/fcif_wait_timer.sv ====
/*
 * fcif_wait_timer: down counter giving the length of one access.
 * assumes load is a single-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module fcif_wait_timer
	import fcif_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	fcif_core_if.timer t
);
	logic [5:0] count_reg;
	logic [5:0] count_next;
	assign count_next = t.load ? t.load_val :
	                    (count_reg != 6'h00) ? count_reg - 6'h01 : count_reg;
	assign t.expired  = (count_reg == 6'h00) && !t.load;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			count_reg <= 6'h00;
		else
			count_reg <= count_next;
	end
endmodule
`default_nettype wire
